// file: wor_bank.sv
/*
 * Write-once option register bank with an Avalon-MM slave port.
 * Each option register latches on its first write after reset and then
 * steers the watchdog, undervoltage monitor, stop logic, serial clock
 * source and oscillator pin setup through registered outputs.
 * Assumes clk at 40 MHz, rst_n for every reset source, por_n asserted
 * only by power-on, and inputs synchronous to clk.
 */
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "wor_regs.svh"

// Operation
// - Each option register takes one write per reset; later writes are ignored.
// - Reset clears all option bits except those with their own reset.
// - Option registers read at any time with no side effect.
// - Watchdog timeout is 8176 cycles with rate bit set, else 262128.
// - With monitor powered, stop-enable bit keeps monitor running in stop.
// - Reset-disable bit blocks undervoltage resets; clear passes them on.
// - Power-disable bit switches the undervoltage monitor off.
// - Range bit selects 5-V mode when set, 3-V mode when clear.
// - Only power-on reset clears the range bit.
// - Stop recovery is 32 cycles with short bit set, else 4096.
// - Stop exit by undervoltage reset always uses the long recovery.
// - Stop-enable bit executes stop; clear makes it an illegal opcode.
// - Baud source bit picks bus clock when set, oscillator clock otherwise.
// - Crystal enable takes no pin without external clock enable; monitor settings follow it alone.
// - Crystal enable sets monitor range: crystal ranges or 60 Hz to 32 MHz.
// - Stabilisation divider is 4096 cycles with crystal, else 16.
// - Slow crystal bit selects slow mode and monitor band below 307.2 kHz.
// - External clock without crystal: pin one clock input, pin two I/O.
// - External clock with crystal: both pins serve the crystal.
// - External clock enable makes pin one a clock input; clear leaves I/O.
module wor_bank
  import wor_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic ce,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic uv_reset_req,
  input wire logic stop_exit_by_uv,
  input wire logic stop_opcode,
  output logic watchdog_enable,
  output logic [17:0] watchdog_timeout,
  output logic uv_monitor_power,
  output logic uv_run_in_stop,
  output logic uv_reset_out,
  output logic uv_mode_5v,
  output logic [12:0] stop_recovery,
  output logic stop_execute,
  output logic stop_illegal,
  output logic keep_oscillator_in_stop,
  output logic baud_from_bus_clock,
  output logic osc_pin_one_clock,
  output logic osc_pin_two_crystal,
  output logic monitor_crystal_range,
  output logic [12:0] monitor_stab_cycles,
  output logic slow_crystal,
  output logic monitor_expect_low
);

  wor_opt_one_t opt_one;
  wor_opt_two_t opt_two;
  wor_opt_one_t opt_one_view;
  wor_lock_t lock;
  logic uv_range;
  logic wr_take;
  logic rd_take;
  logic wr_one;
  logic wr_two;
  logic [31:0] next_readdata;

  // Requests are taken at the edge where waitrequest is already low
  assign wr_take = ce && write && !waitrequest && byteenable[0];
  assign rd_take = ce && read && !waitrequest;
  assign wr_one = wr_take && (address == `WOR_ADDR_OPT_ONE) && !lock.lock_one;
  assign wr_two = wr_take && (address == `WOR_ADDR_OPT_TWO) && !lock.lock_two;

  always_comb begin
    opt_one_view = opt_one;
    opt_one_view.undervoltage_range_select = uv_range;
  end

  // Reads only select; nothing is cleared or advanced by them
  always_comb begin
    next_readdata = `WOR_RDATA_RST;
    unique case (address)
      `WOR_ADDR_OPT_ONE: next_readdata[7:0] = opt_one_view;
      `WOR_ADDR_OPT_TWO: next_readdata[7:0] = opt_two;
      `WOR_ADDR_LOCK: next_readdata[1:0] = lock;
      default: next_readdata = `WOR_RDATA_RST;
    endcase
  end

  // One wait cycle per request, then a single-cycle acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (ce) begin
      if (waitrequest && (read || write)) begin
        waitrequest <= 1'b0;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= `WOR_RDATA_RST;
    end else if (ce && waitrequest && read) begin
      readdata <= next_readdata;
    end
  end

  // A write with byte lane 0 disabled does not use up the one write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock <= '0;
    end else begin
      if (wr_one) begin
        lock.lock_one <= 1'b1;
      end
      if (wr_two) begin
        lock.lock_two <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_one <= `WOR_OPT_ONE_RST;
    end else if (wr_one) begin
      opt_one <= writedata[7:0];
      opt_one.undervoltage_range_select <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_two <= `WOR_OPT_TWO_RST;
    end else if (wr_two) begin
      opt_two <= writedata[7:0] & `WOR_OPT_TWO_MASK;
    end
  end

  // Range bit survives every reset but power-on, hence its own reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      uv_range <= 1'b0;
    end else if (wr_one) begin
      uv_range <= writedata[`WOR_BIT_UV_RANGE];
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      uv_mode_5v <= 1'b0;
    end else if (ce) begin
      uv_mode_5v <= uv_range;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_enable <= 1'b1;
      watchdog_timeout <= `WOR_WDOG_LONG;
    end else if (ce) begin
      watchdog_enable <= !opt_one.watchdog_disable;
      watchdog_timeout <= opt_one.watchdog_rate_select ? `WOR_WDOG_SHORT : `WOR_WDOG_LONG;
    end
  end

  // The monitor's reset path adds one clk of latency to the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_monitor_power <= 1'b1;
      uv_run_in_stop <= 1'b0;
      uv_reset_out <= 1'b0;
    end else if (ce) begin
      uv_monitor_power <= !opt_one.undervoltage_power_disable;
      uv_run_in_stop <= !opt_one.undervoltage_power_disable && opt_one.undervoltage_stop_enable;
      uv_reset_out <= uv_reset_req && !opt_one.undervoltage_reset_disable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_recovery <= `WOR_STOP_LONG;
      stop_execute <= 1'b0;
      stop_illegal <= 1'b0;
    end else if (ce) begin
      if (opt_one.short_stop_recovery && !stop_exit_by_uv) begin
        stop_recovery <= `WOR_STOP_SHORT;
      end else begin
        stop_recovery <= `WOR_STOP_LONG;
      end
      stop_execute <= stop_opcode && opt_one.stop_enable;
      stop_illegal <= stop_opcode && !opt_one.stop_enable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keep_oscillator_in_stop <= 1'b0;
      baud_from_bus_clock <= 1'b0;
      osc_pin_one_clock <= 1'b0;
      osc_pin_two_crystal <= 1'b0;
    end else if (ce) begin
      keep_oscillator_in_stop <= opt_two.keep_oscillator_in_stop;
      baud_from_bus_clock <= opt_two.serial_baud_clock_source;
      osc_pin_one_clock <= opt_two.external_clock_enable;
      // Pin one stays a clock input in crystal mode, so a square wave also works
      osc_pin_two_crystal <= opt_two.external_clock_enable && opt_two.crystal_enable;
    end
  end

  // Monitor settings follow the crystal bit alone; the pin gate is separate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_crystal_range <= 1'b0;
      monitor_stab_cycles <= `WOR_STAB_EXT;
      slow_crystal <= 1'b0;
      monitor_expect_low <= 1'b0;
    end else if (ce) begin
      monitor_crystal_range <= opt_two.crystal_enable;
      monitor_stab_cycles <= opt_two.crystal_enable ? `WOR_STAB_XTAL : `WOR_STAB_EXT;
      slow_crystal <= opt_two.slow_crystal_select;
      monitor_expect_low <= opt_two.slow_crystal_select;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);

  sequence write_one_s;
    ce && write && !waitrequest && byteenable[0] && (address == `WOR_ADDR_OPT_ONE);
  endsequence

  sequence write_two_s;
    ce && write && !waitrequest && byteenable[0] && (address == `WOR_ADDR_OPT_TWO);
  endsequence

  sequence read_req_s;
    ce && read && waitrequest;
  endsequence

  once_one_a: assert property (lock.lock_one ##0 write_one_s |=> $stable(opt_one) && $stable(uv_range))
    else $error("option register one changed after its write");

  once_two_a: assert property (lock.lock_two ##0 write_two_s |=> $stable(opt_two))
    else $error("option register two changed after its write");

  first_write_a: assert property (!lock.lock_one ##0 write_one_s |=> lock.lock_one
      && opt_one.watchdog_disable == $past(writedata[`WOR_BIT_WDOG_DIS]))
    else $error("first write to register one not latched");

  reset_clear_a: assert property (!lock.lock_two |-> opt_two == `WOR_OPT_TWO_RST)
    else $error("unlocked register two not at reset value");

  read_free_a: assert property (read_req_s |-> ##1 (!waitrequest && $stable(opt_one) && $stable(opt_two)
      && $stable(lock)))
    else $error("read acknowledge missing or had a side effect");

  wdog_time_a: assert property (ce |=> watchdog_timeout
      == ($past(opt_one.watchdog_rate_select) ? `WOR_WDOG_SHORT : `WOR_WDOG_LONG))
    else $error("watchdog timeout does not follow the rate bit");

  uv_stop_a: assert property (ce && opt_one.undervoltage_power_disable |=> !uv_run_in_stop && !uv_monitor_power)
    else $error("powered-down monitor kept running in stop");

  uv_reset_a: assert property (ce && uv_reset_req && opt_one.undervoltage_reset_disable |=> !uv_reset_out)
    else $error("blocked undervoltage reset passed on");

  recovery_a: assert property (ce && stop_exit_by_uv |=> stop_recovery == `WOR_STOP_LONG)
    else $error("undervoltage stop exit used short recovery");

  short_rec_a: assert property (ce && opt_one.short_stop_recovery && !stop_exit_by_uv
      |=> stop_recovery == `WOR_STOP_SHORT)
    else $error("short stop recovery not applied");

  stop_op_a: assert property (ce && stop_opcode |=> (stop_execute != stop_illegal)
      && (stop_execute == $past(opt_one.stop_enable)))
    else $error("stop opcode handling wrong");

  pin_two_a: assert property (ce && !opt_two.external_clock_enable |=> !osc_pin_two_crystal && !osc_pin_one_clock)
    else $error("oscillator pin taken without external clock enable");

  stab_div_a: assert property (ce |=> monitor_stab_cycles
      == ($past(opt_two.crystal_enable) ? `WOR_STAB_XTAL : `WOR_STAB_EXT))
    else $error("stabilisation divider does not follow crystal bit");

  ack_once_a: assert property (ce && (read || write) && waitrequest
      |=> !waitrequest)
    else $error("request not acknowledged after one wait cycle");

  ack_drop_a: assert property (ce && !waitrequest
      |=> waitrequest)
    else $error("acknowledge stood longer than one cycle");

  rdata_hold_a: assert property (!(ce && read && waitrequest)
      |=> $stable(readdata))
    else $error("read data changed without a read request");

  lock_clear_a: assert property (!lock.lock_one
      |-> opt_one == `WOR_OPT_ONE_RST)
    else $error("unlocked register one not at reset value");

  range_hold_a: assert property (!wr_one
      |=> $stable(uv_range))
    else $error("range bit changed without a first write");

  uv_power_a: assert property (ce
      |=> uv_monitor_power == !$past(opt_one.undervoltage_power_disable))
    else $error("monitor power does not follow power-disable bit");

  uv_mode_a: assert property (ce
      |=> uv_mode_5v == $past(uv_range))
    else $error("monitor mode does not follow range bit");

  wdog_en_a: assert property (ce
      |=> watchdog_enable == !$past(opt_one.watchdog_disable))
    else $error("watchdog enable does not follow disable bit");

  baud_src_a: assert property (ce
      |=> baud_from_bus_clock == $past(opt_two.serial_baud_clock_source))
    else $error("baud clock source does not follow its bit");

  mon_range_a: assert property (ce
      |=> monitor_crystal_range == $past(opt_two.crystal_enable))
    else $error("monitor range does not follow crystal bit");

  slow_xtal_a: assert property (ce
      |=> slow_crystal == $past(opt_two.slow_crystal_select) && monitor_expect_low == slow_crystal)
    else $error("slow crystal outputs do not follow their bit");

  pin_ext_a: assert property (ce && opt_two.external_clock_enable && !opt_two.crystal_enable
      |=> osc_pin_one_clock && !osc_pin_two_crystal)
    else $error("external clock mode pin setup wrong");

  pin_xtal_a: assert property (ce && opt_two.external_clock_enable && opt_two.crystal_enable
      |=> osc_pin_one_clock && osc_pin_two_crystal)
    else $error("crystal mode pin setup wrong");

endmodule : wor_bank

// file: wor_bank_tb_top.sv
/*
 * Self-checking bench for the write-once option register bank.
 * Assumes wor_pkg and wor_regs.svh are compiled first; the bench acts as Avalon-MM master.
 */
`timescale 1ns/10ps
`include "wor_regs.svh"
module wor_bank_tb_top
  import wor_pkg::*;
;
  logic clk, rst_n, por_n, ce, read, write, waitrequest, uv_reset_req, stop_exit_by_uv, stop_opcode;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rd;
  logic watchdog_enable, uv_monitor_power, uv_run_in_stop, uv_reset_out, uv_mode_5v, stop_execute;
  logic stop_illegal, keep_oscillator_in_stop, baud_from_bus_clock, osc_pin_one_clock;
  logic osc_pin_two_crystal, monitor_crystal_range, slow_crystal, monitor_expect_low;
  logic [17:0] watchdog_timeout;
  logic [12:0] stop_recovery, monitor_stab_cycles;
  logic [7:0] o1s [4] = '{8'hA5, 8'h5A, 8'h46, 8'h08};
  // Short recovery with a crystal needs the oscillator kept running in stop
  logic [7:0] o2s [4] = '{8'h0E, 8'h13, 8'h0A, 8'h04};
  int n_errors = 0;
  int num_checks = 0;

  wor_bank u_wor_bank (.clk, .rst_n, .por_n, .ce, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .uv_reset_req, .stop_exit_by_uv, .stop_opcode, .watchdog_enable,
    .watchdog_timeout, .uv_monitor_power, .uv_run_in_stop, .uv_reset_out, .uv_mode_5v, .stop_recovery,
    .stop_execute, .stop_illegal, .keep_oscillator_in_stop, .baud_from_bus_clock, .osc_pin_one_clock,
    .osc_pin_two_crystal, .monitor_crystal_range, .monitor_stab_cycles, .slow_crystal, .monitor_expect_low);

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // Holds the request until waitrequest is sampled low; read data is taken at that edge
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] data, input logic [3:0] be);
    int i;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= addr;
    writedata <= {24'h000000, data};
    byteenable <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_errors++;
      stop_test();
    end
  endtask : bus

  task automatic do_reset(input logic por);
    @(posedge clk);
    rst_n <= 1'b0;
    por_n <= !por;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask : do_reset

  task automatic check_static(input logic [7:0] o1, input logic [7:0] o2);
    wor_opt_one_t a;
    wor_opt_two_t b;
    a = o1;
    b = o2;
    repeat (3) @(posedge clk);
    check_bit("wdog_en", !a.watchdog_disable, watchdog_enable);
    check_word("wdog_to", {14'h0000, a.watchdog_rate_select ? `WOR_WDOG_SHORT : `WOR_WDOG_LONG},
      {14'h0000, watchdog_timeout});
    check_bit("uv_pwr", !a.undervoltage_power_disable, uv_monitor_power);
    check_bit("uv_stop", !a.undervoltage_power_disable & a.undervoltage_stop_enable, uv_run_in_stop);
    check_bit("uv_5v", a.undervoltage_range_select, uv_mode_5v);
    check_word("stop_rec", {19'h00000, a.short_stop_recovery ? `WOR_STOP_SHORT : `WOR_STOP_LONG},
      {19'h00000, stop_recovery});
    check_bit("keep_osc", b.keep_oscillator_in_stop, keep_oscillator_in_stop);
    check_bit("baud_src", b.serial_baud_clock_source, baud_from_bus_clock);
    check_bit("pin_one", b.external_clock_enable, osc_pin_one_clock);
    check_bit("pin_two", b.external_clock_enable & b.crystal_enable, osc_pin_two_crystal);
    check_bit("mon_xtal", b.crystal_enable, monitor_crystal_range);
    check_word("stab", {19'h00000, b.crystal_enable ? `WOR_STAB_XTAL : `WOR_STAB_EXT},
      {19'h00000, monitor_stab_cycles});
    check_bit("slow", b.slow_crystal_select, slow_crystal);
    check_bit("mon_low", b.slow_crystal_select, monitor_expect_low);
  endtask : check_static

  // Reads every place after a reset; range bit survives anything but power-on
  task automatic t_reset(input logic range);
    bus(1'b0, `WOR_ADDR_OPT_ONE, 8'h00, 4'hF);
    check_word("opt_one", {28'h0000000, range, 3'h0}, rd);
    bus(1'b0, `WOR_ADDR_OPT_TWO, 8'h00, 4'hF);
    check_word("opt_two", 32'h00000000, rd);
    bus(1'b0, `WOR_ADDR_LOCK, 8'h00, 4'hF);
    check_word("lock", 32'h00000000, rd);
    bus(1'b0, 4'hC, 8'h00, 4'hF);
    check_word("unmapped", 32'h00000000, rd);
    check_static({4'h0, range, 3'h0}, 8'h00);
  endtask : t_reset

  task automatic t_write_once(input logic [7:0] o1, input logic [7:0] o2);
    bus(1'b1, `WOR_ADDR_OPT_ONE, o1, 4'hE);
    bus(1'b0, `WOR_ADDR_LOCK, 8'h00, 4'hF);
    check_word("lock_none", 32'h00000000, rd);
    bus(1'b1, `WOR_ADDR_OPT_ONE, o1, 4'h1);
    bus(1'b0, `WOR_ADDR_LOCK, 8'h00, 4'hF);
    check_word("lock_one", 32'h00000001, rd);
    bus(1'b1, `WOR_ADDR_OPT_TWO, o2, 4'h1);
    bus(1'b1, `WOR_ADDR_OPT_ONE, ~o1, 4'h1);
    bus(1'b1, `WOR_ADDR_OPT_TWO, ~o2, 4'h1);
    bus(1'b1, `WOR_ADDR_LOCK, 8'h00, 4'h1);
    bus(1'b0, `WOR_ADDR_LOCK, 8'h00, 4'hF);
    check_word("lock_both", 32'h00000003, rd);
    bus(1'b0, `WOR_ADDR_OPT_ONE, 8'h00, 4'hF);
    check_word("opt_one", {24'h000000, o1}, rd);
    bus(1'b0, `WOR_ADDR_OPT_TWO, 8'h00, 4'hF);
    check_word("opt_two", {24'h000000, o2}, rd);
  endtask : t_write_once

  task automatic t_outputs(input logic [7:0] o1, input logic [7:0] o2);
    check_static(o1, o2);
    uv_reset_req <= 1'b1;
    stop_exit_by_uv <= 1'b1;
    repeat (3) @(posedge clk);
    check_bit("uv_rst", !o1[`WOR_BIT_UV_RST_DIS], uv_reset_out);
    check_word("stop_uv", {19'h00000, `WOR_STOP_LONG}, {19'h00000, stop_recovery});
    uv_reset_req <= 1'b0;
    stop_exit_by_uv <= 1'b0;
    stop_opcode <= 1'b1;
    @(posedge clk);
    stop_opcode <= 1'b0;
    @(posedge clk);
    check_bit("stop_ex", o1[`WOR_BIT_STOP_EN], stop_execute);
    check_bit("stop_ill", !o1[`WOR_BIT_STOP_EN], stop_illegal);
    @(posedge clk);
    check_bit("stop_end", 1'b0, stop_execute | stop_illegal);
    check_bit("uv_rst_end", 1'b0, uv_reset_out);
    // Clock enable low must freeze the registered outputs
    ce <= 1'b0;
    uv_reset_req <= 1'b1;
    repeat (3) @(posedge clk);
    check_bit("ce_hold", 1'b0, uv_reset_out);
    ce <= 1'b1;
    uv_reset_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : t_outputs

  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    ce = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    uv_reset_req = 1'b0;
    stop_exit_by_uv = 1'b0;
    stop_opcode = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_reset(1'b0);
    for (int k = 0; k < 4; k++) begin
      t_write_once(o1s[k], o2s[k]);
      t_outputs(o1s[k], o2s[k]);
      do_reset(1'b0);
      t_reset(o1s[k][`WOR_BIT_UV_RANGE]);
    end
    do_reset(1'b1);
    t_reset(1'b0);
    stop_test();
  end
endmodule : wor_bank_tb_top

// file: wor_pkg.sv
/*
 * Types of the write-once option register bank.
 * Assumes wor_regs.svh is on the include path.
 */
package wor_pkg;

  `include "wor_regs.svh"

  typedef struct packed {
    logic watchdog_rate_select;
    logic undervoltage_stop_enable;
    logic undervoltage_reset_disable;
    logic undervoltage_power_disable;
    logic undervoltage_range_select;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } wor_opt_one_t;

  typedef struct packed {
    logic [2:0] unused;
    logic slow_crystal_select;
    logic external_clock_enable;
    logic crystal_enable;
    logic keep_oscillator_in_stop;
    logic serial_baud_clock_source;
  } wor_opt_two_t;

  typedef struct packed {
    logic lock_two;
    logic lock_one;
  } wor_lock_t;

endpackage : wor_pkg

// file: wor_regs.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * write-once option register bank.
 * Assumes inclusion by bare name from the package and the bank module.
 */
`ifndef WOR_REGS_SVH
`define WOR_REGS_SVH

// Byte addresses on the register bus
`define WOR_ADDR_OPT_ONE 4'h0
`define WOR_ADDR_OPT_TWO 4'h4
`define WOR_ADDR_LOCK 4'h8

// Reset values
`define WOR_OPT_ONE_RST 8'h00
`define WOR_OPT_TWO_RST 8'h00
`define WOR_RDATA_RST 32'h0000_0000

// Field positions, option register one
`define WOR_BIT_WDOG_DIS 0
`define WOR_BIT_STOP_EN 1
`define WOR_BIT_SHORT_STOP 2
`define WOR_BIT_UV_RANGE 3
`define WOR_BIT_UV_PWR_DIS 4
`define WOR_BIT_UV_RST_DIS 5
`define WOR_BIT_UV_STOP_EN 6
`define WOR_BIT_WDOG_RATE 7

// Field positions, option register two
`define WOR_BIT_BAUD_SRC 0
`define WOR_BIT_KEEP_OSC 1
`define WOR_BIT_XTAL_EN 2
`define WOR_BIT_EXT_CLK_EN 3
`define WOR_BIT_SLOW_XTAL 4
`define WOR_OPT_TWO_MASK 8'h1F

// Timing counts in oscillator clock cycles
`define WOR_WDOG_SHORT 18'h01FF0
`define WOR_WDOG_LONG 18'h3FFF0
`define WOR_STOP_SHORT 13'h0020
`define WOR_STOP_LONG 13'h1000
`define WOR_STAB_XTAL 13'h1000
`define WOR_STAB_EXT 13'h0010

`endif
